/* src/mos_pkg.sv */
package mos_pkg;

  // system clock rate and the base tick used by every timer
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_MS     = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // timer figures, in milliseconds
  localparam int unsigned SIMUL_MS    = 3000;  // pair simultaneity window
  localparam int unsigned OVR_MS      = 10000; // length of one override
  localparam int unsigned REARM_MS    = 3000;  // both-open time before rearm
  localparam int unsigned RST_MIN_MS  = 250;   // shortest valid reset closure
  localparam int unsigned RST_MAX_MS  = 2000;  // longest valid reset closure
  localparam int unsigned RESP_MS     = 10;    // worst stop response allowed

  // width of every millisecond counter
  localparam int unsigned MS_W        = 14;

  // reset values of control state
  localparam logic        RUN_RST     = 1'b0;
  localparam logic        MUTE_RST    = 1'b0;
  localparam logic        FAULT_RST   = 1'b0;

  // state of one two-contact simultaneity checker
  typedef enum logic [3:0] {
    PAIR_IDLE = 4'b0001,  // both contacts open
    PAIR_ONE  = 4'b0010,  // one closed, window running
    PAIR_OK   = 4'b0100,  // both closed within the window
    PAIR_LATE = 4'b1000   // blocked until both open again
  } mos_pair_st_t;

  // override sequencer state
  typedef enum logic [2:0] {
    OVR_ARM   = 3'b001,   // waiting for both channels open long enough
    OVR_READY = 3'b010,   // armed, next good closure is accepted
    OVR_RUN   = 3'b100    // override in progress
  } mos_ovr_st_t;

endpackage

/* src/mos_pair.sv */
`timescale 1ns/1ps
module mos_pair
  import mos_pkg::*;
#(
  parameter int unsigned WIN_MS = SIMUL_MS
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // millisecond tick
  input  wire logic tick,
  // the two contacts, high when closed
  input  wire logic close_a,
  input  wire logic close_b,
  // both closed and qualified
  output logic      ok
);

  if (WIN_MS < 1 || WIN_MS >= (1 << MS_W)) begin : g_chk
    $error("mos_pair: WIN_MS out of range");
  end

  localparam logic [MS_W-1:0] WIN = MS_W'(WIN_MS);

  typedef struct packed {
    mos_pair_st_t    st;   // checker state
    logic [MS_W-1:0] cnt;  // ms since the first contact closed
  } mos_pair_s_t;

  mos_pair_s_t cur;
  mos_pair_s_t next_cur;

  // simultaneity state machine
  always_comb begin
    next_cur = cur;
    case (cur.st)
      PAIR_IDLE: begin
        next_cur.cnt = '0;
        if (close_a && close_b) begin
          next_cur.st = PAIR_OK;
        end else if (close_a || close_b) begin
          next_cur.st = PAIR_ONE;
        end
      end
      PAIR_ONE: begin
        if (close_a && close_b) begin
          next_cur.st = PAIR_OK;
        end else if (!close_a && !close_b) begin
          next_cur.st = PAIR_IDLE;
        end else if (cur.cnt >= WIN) begin
          // second contact too late: hold off until both reopen
          next_cur.st = PAIR_LATE;
        end else if (tick) begin
          next_cur.cnt = cur.cnt + MS_W'(1);
        end
      end
      PAIR_OK: begin
        // losing either contact ends qualification and forces a reopen
        if (!close_a && !close_b) begin
          next_cur.st = PAIR_IDLE;
        end else if (!close_a || !close_b) begin
          next_cur.st = PAIR_LATE;
        end
      end
      PAIR_LATE: begin
        if (!close_a && !close_b) begin
          next_cur.st = PAIR_IDLE;
        end
      end
      default: next_cur.st = PAIR_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{st: PAIR_IDLE, cnt: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // window met: both closed within WIN_MS of one another
  assign ok = (cur.st == PAIR_OK);

endmodule // mos_pair

/* src/mos_seq.sv */
`timescale 1ns/1ps
// What this block does
// - sensors one-two and three-four form pairs
// - pair must close within three seconds
// - gating option: start mute only when gated
// - gate dropping mid-mute is ignored
// - gating option off: gate input ignored
// - override channels close within three seconds
// - override lasts ten seconds while held
// - rearm: both open three seconds first
// - reset closure 0.25 to 2.0 seconds
// - two feedback channels watch external devices
// - mute keeps safety outputs on
// - unmuted, no override: stop input opening drops outputs
// - universal stop never muted, always drops
// - stop opening drops outputs within 10ms
module mos_seq
  import mos_pkg::*;
#(
  parameter int unsigned TICK_CYC   = TICK_CYCLES, // clocks per ms tick
  parameter int unsigned SIMUL_WIN  = SIMUL_MS,    // pair window, ms
  parameter int unsigned OVR_LEN    = OVR_MS,      // override length, ms
  parameter int unsigned REARM_LEN  = REARM_MS,    // rearm open time, ms
  parameter int unsigned RST_MIN    = RST_MIN_MS,  // reset closure min, ms
  parameter int unsigned RST_MAX    = RST_MAX_MS   // reset closure max, ms
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // muting sensors, high when closed
  input  wire logic       mute_sensor_one,
  input  wire logic       mute_sensor_two,
  input  wire logic       mute_sensor_three,
  input  wire logic       mute_sensor_four,
  // mute gating option and input
  input  wire logic       mute_gate_enable,
  input  wire logic       mute_gate,
  // two-channel override switch, high when closed
  input  wire logic       override_a,
  input  wire logic       override_b,
  // reset switch, high when closed
  input  wire logic       reset_switch,
  // stop inputs, two channels each, high when closed
  input  wire logic [1:0] muteable_stop_input,
  input  wire logic [1:0] universal_stop_input,
  // feedback from external devices, high when released
  input  wire logic       feedback_enable,
  input  wire logic [1:0] external_feedback_monitor,
  // results
  output logic      [1:0] safety_output,
  output logic            mute_active,
  output logic            override_active,
  output logic            feedback_fault
);

  // refuse settings the counters cannot hold
  if (TICK_CYC < 1 || TICK_CYC >= (1 << 20)) begin : g_chk_tick
    $error("mos_seq: TICK_CYC out of range");
  end
  if (OVR_LEN < 1 || OVR_LEN >= (1 << MS_W) ||
      REARM_LEN < 1 || REARM_LEN >= (1 << MS_W)) begin : g_chk_ovr
    $error("mos_seq: override timing out of range");
  end
  if (RST_MIN < 1 || RST_MAX <= RST_MIN ||
      RST_MAX >= (1 << MS_W) - 1) begin : g_chk_rst
    $error("mos_seq: reset timing out of range");
  end

  localparam logic [19:0]     TICK_TOP = 20'(TICK_CYC - 1);
  localparam logic [MS_W-1:0] OVR_T    = MS_W'(OVR_LEN);
  localparam logic [MS_W-1:0] REARM_T  = MS_W'(REARM_LEN);
  localparam logic [MS_W-1:0] RST_LO   = MS_W'(RST_MIN);
  localparam logic [MS_W-1:0] RST_HI   = MS_W'(RST_MAX);
  localparam logic [MS_W-1:0] RST_SAT  = MS_W'(RST_MAX + 1);

  // both channels of a two-channel contact are closed
  function automatic logic both(input logic [1:0] ch);
    both = ch[0] & ch[1];
  endfunction

  // all state of the sequencer
  typedef struct packed {
    logic [19:0]     tick_cnt;  // clocks within the current ms
    logic            tick;      // one-cycle ms strobe
    mos_ovr_st_t     ovr_st;    // override sequencer
    logic [MS_W-1:0] ovr_cnt;   // ms in arm or run phase
    logic [MS_W-1:0] rst_cnt;   // ms the reset switch has been closed
    logic            rst_prev;  // reset switch last cycle
    logic            run;       // latched permission for the outputs
    logic            mute;      // mute in progress
    logic [1:0]      out;       // safety outputs
    logic            ovr;       // override in progress
    logic            fault;     // feedback mismatch seen at reset
  } mos_seq_s_t;

  mos_seq_s_t cur;
  mos_seq_s_t next_cur;

  // qualifier channels: pair 1/2, pair 3/4, override
  logic [2:0] ch_a;
  logic [2:0] ch_b;
  logic [2:0] ch_ok;

  assign ch_a = {override_a, mute_sensor_three, mute_sensor_one};
  assign ch_b = {override_b, mute_sensor_four, mute_sensor_two};

  // one simultaneity checker per pair, same window for all
  for (genvar i = 0; i < 3; i++) begin : g_pair
    mos_pair #(
      .WIN_MS  (SIMUL_WIN)
    ) u_pair (
      .clock   (clock),
      .rst_n   (rst_n),
      .tick    (cur.tick),
      .close_a (ch_a[i]),
      .close_b (ch_b[i]),
      .ok      (ch_ok[i])
    );
  end

  // conditions seen by the sequencer
  logic pair_any;
  logic gate_ok;
  logic usi_ok;
  logic msi_ok;
  logic keep_on;
  logic rst_valid;

  always_comb begin
    // either pair qualified starts or holds a mute
    pair_any  = ch_ok[0] | ch_ok[1];
    // gate counts only with the option selected
    gate_ok   = !mute_gate_enable || mute_gate;
    // universal stop is never bypassed
    usi_ok    = both(universal_stop_input);
    // muteable stop is bypassed while muted or overridden
    msi_ok    = both(muteable_stop_input) || cur.mute
                || cur.ovr;
    keep_on   = usi_ok && msi_ok;
    // release after a closure of the allowed length
    rst_valid = cur.rst_prev && !reset_switch &&
                cur.rst_cnt >= RST_LO &&
                cur.rst_cnt <= RST_HI;
  end

  // next-state logic
  always_comb begin
    next_cur = cur;

    // ms tick generator
    next_cur.tick = 1'b0;
    if (cur.tick_cnt >= TICK_TOP) begin
      next_cur.tick_cnt = '0;
      next_cur.tick     = 1'b1;
    end else begin
      next_cur.tick_cnt = cur.tick_cnt + 20'(1);
    end

    // reset switch closure length, saturating past the maximum
    next_cur.rst_prev = reset_switch;
    if (!reset_switch) begin
      next_cur.rst_cnt = '0;
    end else if (cur.tick && cur.rst_cnt < RST_SAT) begin
      next_cur.rst_cnt = cur.rst_cnt + MS_W'(1);
    end

    // mute: start needs a pair and the gate, hold needs only a pair
    if (!cur.mute) begin
      if (pair_any && gate_ok && cur.run) begin
        next_cur.mute = 1'b1;
      end
    end else if (!pair_any) begin
      // the gate is not looked at here on purpose
      next_cur.mute = 1'b0;
    end

    // override sequencer
    case (cur.ovr_st)
      OVR_ARM: begin
        next_cur.ovr = 1'b0;
        if (override_a || override_b) begin
          next_cur.ovr_cnt = '0;
        end else if (cur.ovr_cnt >= REARM_T) begin
          next_cur.ovr_st  = OVR_READY;
        end else if (cur.tick) begin
          next_cur.ovr_cnt = cur.ovr_cnt + MS_W'(1);
        end
      end
      OVR_READY: begin
        next_cur.ovr_cnt = '0;
        if (ch_ok[2]) begin
          // both channels closed within the window
          next_cur.ovr_st = OVR_RUN;
          next_cur.ovr    = 1'b1;
        end else if (!override_a && !override_b) begin
          next_cur.ovr_st = OVR_READY;
        end
      end
      OVR_RUN: begin
        if (!ch_ok[2]) begin
          // a channel let go: stop now and demand a fresh rearm
          next_cur.ovr_st  = OVR_ARM;
          next_cur.ovr     = 1'b0;
          next_cur.ovr_cnt = '0;
        end else if (cur.ovr_cnt >= OVR_T) begin
          next_cur.ovr_st  = OVR_ARM;
          next_cur.ovr     = 1'b0;
          next_cur.ovr_cnt = '0;
        end else if (cur.tick) begin
          next_cur.ovr_cnt = cur.ovr_cnt + MS_W'(1);
        end
      end
      default: begin
        next_cur.ovr_st  = OVR_ARM;
        next_cur.ovr     = 1'b0;
        next_cur.ovr_cnt = '0;
      end
    endcase

    // run latch: a trip clears it, a valid reset sets it again
    if (!keep_on) begin
      next_cur.run = 1'b0;
    end else if (rst_valid) begin
      // outputs must be off and both devices released before a restart
      if (!cur.run && feedback_enable &&
          !both(external_feedback_monitor)) begin
        next_cur.fault = 1'b1;
      end else begin
        next_cur.run   = 1'b1;
        next_cur.fault = 1'b0;
      end
    end

    // while run is set with the outputs still off, a stuck device is also a fault
    if (cur.run && feedback_enable && cur.out == 2'h0 &&
        !both(external_feedback_monitor)) begin
      next_cur.fault = 1'b1;
    end

    // outputs follow the stop condition in the very next cycle
    next_cur.out = (keep_on && next_cur.run) ? 2'h3 : 2'h0;
  end

  // the single state register of the sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{tick_cnt: '0, tick: 1'b0, ovr_st: OVR_ARM, ovr_cnt: '0,
               rst_cnt: '0, rst_prev: 1'b0, run: RUN_RST, mute: MUTE_RST,
               out: 2'h0, ovr: 1'b0, fault: FAULT_RST};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign safety_output   = cur.out;
  assign mute_active     = cur.mute;
  assign override_active = cur.ovr;
  assign feedback_fault  = cur.fault;

endmodule // mos_seq

/* dv/mos_seq_monitor.sv */
`timescale 1ns/1ps
// watches the sequencer ports only
module mos_seq_monitor
  import mos_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned OVR_LEN  = OVR_MS
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // field inputs
  input wire logic       mute_sensor_one,
  input wire logic       mute_sensor_two,
  input wire logic       mute_sensor_three,
  input wire logic       mute_sensor_four,
  input wire logic       mute_gate_enable,
  input wire logic       mute_gate,
  input wire logic       override_a,
  input wire logic       override_b,
  input wire logic [1:0] muteable_stop_input,
  input wire logic [1:0] universal_stop_input,
  // results
  input wire logic [1:0] safety_output,
  input wire logic       mute_active,
  input wire logic       override_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // two ticks of slack, since timers only step on the tick
  localparam int OVR_MAX = (OVR_LEN + 2) * TICK_CYC;
  logic [31:0] ovr_cyc; // cycles the override has stood
  // count the current override run
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ovr_cyc <= 32'h0;
    else if (override_active) ovr_cyc <= ovr_cyc + 32'h1;
    else ovr_cyc <= 32'h0;
  end
  // pair one-two held, pair three-four open, universal stop closed
  sequence s_p12;
    mute_sensor_one && mute_sensor_two && !mute_sensor_three &&
    !mute_sensor_four && universal_stop_input == 2'h3;
  endsequence
  property p_usi; universal_stop_input != 2'h3 |=> safety_output == 2'h0;
  endproperty
  a_usi: assert property (p_usi) else $error("stop not obeyed");
  property p_msi; muteable_stop_input != 2'h3 && !mute_active &&
    !override_active |=> safety_output == 2'h0; endproperty
  a_msi: assert property (p_msi) else $error("msi trip");
  property p_keep; mute_active && universal_stop_input == 2'h3 &&
    safety_output == 2'h3 |=> safety_output == 2'h3; endproperty
  a_keep: assert property (p_keep) else $error("mute drop");
  property p_pair; $rose(mute_active) |-> $past((mute_sensor_one &&
    mute_sensor_two) || (mute_sensor_three && mute_sensor_four), 2);
  endproperty
  a_pair: assert property (p_pair) else $error("no pair");
  property p_gate; $rose(mute_active) && $past(mute_gate_enable) |->
    $past(mute_gate); endproperty
  a_gate: assert property (p_gate) else $error("ungated");
  property p_hold; s_p12[*3] ##0 (mute_active && !mute_gate) |=>
    mute_active; endproperty
  a_hold: assert property (p_hold) else $error("gate obeyed");
  property p_ovr; $rose(override_active) |->
    $past(override_a && override_b, 2); endproperty
  a_ovr: assert property (p_ovr) else $error("ovr start");
  property p_early; override_active && !(override_a && override_b) |->
    ##[1:2] !override_active; endproperty
  a_early: assert property (p_early) else $error("ovr held");
  property p_len; ovr_cyc <= OVR_MAX; endproperty
  a_len: assert property (p_len) else $error("ovr too long");
  c_mute: cover property ($rose(mute_active));
  c_ovr: cover property ($rose(override_active));
  c_on: cover property ($rose(safety_output[0]));
endmodule // mos_seq_monitor

bind mos_seq mos_seq_monitor #(
  .TICK_CYC(TICK_CYC),
  .OVR_LEN (OVR_LEN)
) i_mon (
  .clock, .rst_n, .mute_sensor_one, .mute_sensor_two,
  .mute_sensor_three, .mute_sensor_four, .mute_gate_enable,
  .mute_gate, .override_a, .override_b, .muteable_stop_input,
  .universal_stop_input, .safety_output, .mute_active,
  .override_active
);

/* dv/mos_field.sv */
`timescale 1ns/1ps
// external contactors driven by the safety outputs, read back
module mos_field (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // drive from the sequencer
  input  wire logic [1:0] safety_output,
  // high makes both contacts read as welded
  input  wire logic       stuck,
  // readback, high when released
  output logic      [1:0] external_feedback_monitor
);
  logic [1:0] pulled; // armature state, one cycle of lag
  // a welded contact never reports released
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulled <= 2'h0;
      external_feedback_monitor <= 2'h3;
    end else begin
      pulled <= safety_output;
      external_feedback_monitor <= stuck ? 2'h0 : ~pulled;
    end
  end
endmodule // mos_field

/* dv/mos_seq_tb.sv */
`timescale 1ns/1ps
module mos_seq_tb;
  import mos_pkg::*;
  localparam int TC = 10; // clocks per tick, short for simulation
  logic       clock, rst_n, gate_en, gate, ov_a, ov_b, rst_sw, stuck, fb_en;
  logic [3:0] sen;        // muting sensors one to four
  logic [1:0] msi, usi, fb, so;
  logic       mute, ovr, fault;
  int         num_errors, checks;
  always #10 clock = ~clock;
  mos_seq #(.TICK_CYC(TC), .SIMUL_WIN(5), .OVR_LEN(20), .REARM_LEN(5),
    .RST_MIN(3), .RST_MAX(8)) i_dut (.clock(clock), .rst_n(rst_n),
    .mute_sensor_one(sen[0]), .mute_sensor_two(sen[1]),
    .mute_sensor_three(sen[2]), .mute_sensor_four(sen[3]),
    .mute_gate_enable(gate_en), .mute_gate(gate), .override_a(ov_a),
    .override_b(ov_b), .reset_switch(rst_sw), .muteable_stop_input(msi),
    .universal_stop_input(usi), .feedback_enable(fb_en),
    .external_feedback_monitor(fb), .safety_output(so),
    .mute_active(mute), .override_active(ovr), .feedback_fault(fault));
  mos_field i_field (.clock(clock), .rst_n(rst_n), .safety_output(so),
    .stuck(stuck), .external_feedback_monitor(fb));
  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic ms(input int n);
    cyc(n * TC);
  endtask
  task automatic chk(input logic [1:0] g, input logic [1:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // operator reset closure of n ms
  task automatic pulse(input int n);
    rst_sw = 1'b1;
    ms(n);
    rst_sw = 1'b0;
    cyc(4);
  endtask
  task automatic t_reset;
    chk(so, 2'h0);
    pulse(1);
    chk(so, 2'h0);
    pulse(12);
    chk(so, 2'h0);
    pulse(5);
    chk(so, 2'h3);
  endtask
  task automatic t_stops;
    stuck = 1'b1;
    usi = 2'h2;
    cyc(2);
    chk(so, 2'h0);
    usi = 2'h3;
    pulse(5);
    chk({1'b0, fault}, 2'h1);
    chk(so, 2'h0);
    stuck = 1'b0;
    cyc(3);
    pulse(5);
    chk({1'b0, fault}, 2'h0);
    msi = 2'h1;
    cyc(2);
    chk(so, 2'h0);
    msi = 2'h3;
    pulse(5);
    // monitoring off: a welded contact no longer blocks a restart
    usi = 2'h2;
    cyc(2);
    stuck = 1'b1;
    fb_en = 1'b0;
    usi = 2'h3;
    cyc(3);
    pulse(5);
    chk(so, 2'h3);
    chk({1'b0, fault}, 2'h0);
    stuck = 1'b0;
    fb_en = 1'b1;
    cyc(3);
  endtask
  task automatic t_mute;
    gate_en = 1'b1;
    sen = 4'h5;
    cyc(4);
    chk({1'b0, mute}, 2'h0);
    sen = 4'h0;
    cyc(2);
    sen = 4'h3;
    cyc(4);
    chk({1'b0, mute}, 2'h0);
    gate = 1'b1;
    cyc(3);
    chk({1'b0, mute}, 2'h1);
    gate = 1'b0;
    msi = 2'h0;
    cyc(4);
    chk({1'b0, mute}, 2'h1);
    chk(so, 2'h3);
    msi = 2'h3;
    sen = 4'h0;
    // gating off here, so only the late pair can hold the mute back
    gate_en = 1'b0;
    cyc(4);
    sen = 4'h4;
    ms(8);
    sen = 4'hC;
    cyc(4);
    chk({1'b0, mute}, 2'h0);
    sen = 4'h0;
    cyc(2);
    sen = 4'h4;
    ms(2);
    sen = 4'hC;
    cyc(3);
    chk({1'b0, mute}, 2'h1);
    usi = 2'h1;
    cyc(2);
    chk(so, 2'h0);
    usi = 2'h3;
    sen = 4'h0;
    pulse(5);
  endtask
  task automatic t_override;
    ms(8);
    ov_a = 1'b1;
    ms(2);
    ov_b = 1'b1;
    cyc(4);
    chk({1'b0, ovr}, 2'h1);
    msi = 2'h0;
    ms(17);
    chk(so, 2'h3);
    msi = 2'h3;
    ms(5);
    chk({1'b0, ovr}, 2'h0);
    {ov_a, ov_b} = 2'h0;
    ms(2);
    {ov_a, ov_b} = 2'h3;
    cyc(4);
    chk({1'b0, ovr}, 2'h0);
    {ov_a, ov_b} = 2'h0;
    ms(8);
    {ov_a, ov_b} = 2'h3;
    cyc(4);
    chk({1'b0, ovr}, 2'h1);
    ov_a = 1'b0;
    cyc(3);
    chk({1'b0, ovr}, 2'h0);
    ov_b = 1'b0;
    ms(8);
    ov_b = 1'b1;
    ms(8);
    ov_a = 1'b1;
    cyc(4);
    chk({1'b0, ovr}, 2'h0);
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog, far beyond the roughly 1,200 cycles of the run
  initial begin
    #1_000_000;
    num_errors++;
    end_sim();
  end
  initial begin
    {clock, rst_n, gate_en, gate, ov_a, ov_b, rst_sw, stuck} = 8'h00;
    {sen, msi, usi} = 8'h0F;
    {num_errors, checks} = 64'h0;
    fb_en = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_stops();
    t_mute();
    t_override();
    end_sim();
  end
endmodule // mos_seq_tb
